/* sinc3_consts.vh */
// Constants for the third-order sinc decimator and its conversion sequencer
`ifndef SINC3_CONSTS_VH
`define SINC3_CONSTS_VH

// ----------------------------------------------------------------------
// Modulator timing
// ----------------------------------------------------------------------
`define MOD_CLKS        16
`define MOD_CNT_W       4
`define DELAY_DEFAULT   14
`define DELAY_1         32
`define DELAY_2         64
`define DELAY_3         128
`define DELAY_4         256
`define DELAY_5         512
`define DELAY_6         1024
`define DELAY_7         2048
`define OVH_SLOW        65
`define OVH_FAST        40

// ----------------------------------------------------------------------
// Data rate codes and decimation ratios in modulator periods
// ----------------------------------------------------------------------
`define RATE_W          4
`define RATE_FAST_FIRST 4'hB
`define RATE_LAST       4'hD
`define RATIO_0         102400
`define RATIO_1         51200
`define RATIO_2         25600
`define RATIO_3         15360
`define RATIO_4         12800
`define RATIO_5         5120
`define RATIO_6         4264
`define RATIO_7         2560
`define RATIO_8         1280
`define RATIO_9         640
`define RATIO_10        320
`define RATIO_11        256
`define RATIO_12        128
`define RATIO_13        64

// ----------------------------------------------------------------------
// Widths and settling
// ----------------------------------------------------------------------
`define CNT_W           20
`define ACC_W           52
`define RESULT_W        16
`define SUPPRESSED      2'h2
`define FIFO_DEPTH      8
`define FILTER_SINC     1'b0

`endif

/* result_fifo.v */
// Result FIFO between the conversion sequencer and the host read side
`default_nettype none

module result_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8
) (
    input  wire             clock,     // System clock
    input  wire             rst_b,     // Asynchronous reset, active low
    input  wire             in_valid,  // Word offered
    output reg              in_ready,  // Room for a word
    input  wire [WIDTH-1:0] in_data,   // Word to store
    output reg              out_valid, // Word available
    input  wire             out_ready, // Reader takes the word
    output wire [WIDTH-1:0] out_data   // Oldest word
);

    function integer clog2;
        input integer v;
        integer n;
        begin
            n = 0;
            while ((1 << n) < v) n = n + 1;
            clog2 = (n < 1) ? 1 : n;
        end
    endfunction

    localparam AW = clog2(DEPTH);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    wire            push;
    wire            pop;
    wire [AW:0]     next_count;

    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    assign out_data   = mem[rd_ptr];

    // ------------------------------------------------------------------
    // Pointers and flags
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            count     <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (push)
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            count     <= next_count;
            in_ready  <= (next_count != DEPTH[AW:0]);
            out_valid <= (next_count != {(AW+1){1'b0}});
        end
    end

    // Storage has no reset; only words behind out_valid are ever read
    always @(posedge clock) begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

endmodule

`default_nettype wire

/* sinc3_decimator.v */
// Third-order sinc decimator with first/subsequent conversion timing
`include "sinc3_consts.vh"
`default_nettype none

// How it works
// [RULE1] Sinc3 decimates modulator bits taken every 16 clocks by the chosen ratio.
// [RULE2] Decimation ratio equals one data period, so nulls sit at rate multiples.
// [RULE3] Ratios for 2.5, 5 and 10 SPS null both 50 and 60 Hz.
// [RULE4] 16.6 and 50 SPS null 50 Hz; 20 and 60 SPS null 60 Hz.
// [RULE5] Bandwidth follows the ratio, 0.65 Hz at 2.5 SPS to 1046 Hz.
// [RULE6] All timing counts modulator ticks of the clock, so it scales with it.
// [RULE7] First two outputs after a start are discarded; only settled data leaves.
// [RULE8] First result comes delay plus three periods plus overhead after start.
// [RULE9] Continuous results follow each other by exactly one data period.
// [RULE10] Start on trigger pin rising edge or the start command pulse.
// [RULE11] Three-bit delay select before the first conversion, default 14 periods.
// [RULE12] Delay applies only to the first conversion after a start.
// [RULE13] First conversion is delay, sampling, then compensation overhead.
// [RULE14] Suppressed outputs get no overhead and are never readable.
// [RULE15] Sinc path starts only while the filter select input is zero; later changes do not stop it.
// [RULE16] Single-shot stops after the first settled result until a new start.
// [RULE17] Data-ready pulses for each released result, never for suppressed ones.
module sinc3_decimator #(
    parameter RATIO_SHIFT = 0,   // Divides every ratio by 2**shift for short runs
    parameter FIFO_DEPTH  = `FIFO_DEPTH
) (
    input  wire                 clock,       // 10 MHz ADC clock
    input  wire                 rst_b,       // Asynchronous reset, active low
    input  wire                 start_pin,   // Conversion trigger pin
    input  wire                 start_cmd,   // Start command pulse, same clock
    input  wire                 mod_bit,     // Modulator bit stream pin
    input  wire                 filter_sel,  // 0 selects the sinc filter
    input  wire                 continuous,  // 1 continuous, 0 single-shot
    input  wire [`RATE_W-1:0]   rate_sel,    // Data rate code 0..13
    input  wire [2:0]           delay_sel,   // Pre-conversion delay select
    input  wire [15:0]          offset_cal,  // Offset removed during overhead
    output wire                 out_valid,   // Result waiting for the host
    input  wire                 out_ready,   // Host takes the result
    output wire [15:0]          out_data,    // Settled, compensated result
    output reg                  data_ready,  // One-cycle pulse per released result
    output reg                  busy         // Converting
);

    // ------------------------------------------------------------------
    // States and helpers
    // ------------------------------------------------------------------
    localparam S_IDLE    = 6'h01;
    localparam S_DELAY   = 6'h02;
    localparam S_SAMPLE  = 6'h04;
    localparam S_OVH     = 6'h08;
    localparam S_RELEASE = 6'h10;
    localparam S_RUN     = 6'h20;

    function [`CNT_W-1:0] rate_ratio;
        input [`RATE_W-1:0] code;
        reg [31:0] r;
        begin
            case (code)
                4'h0:    r = `RATIO_0;
                4'h1:    r = `RATIO_1;
                4'h2:    r = `RATIO_2;
                4'h3:    r = `RATIO_3;
                4'h4:    r = `RATIO_4;
                4'h5:    r = `RATIO_5;
                4'h6:    r = `RATIO_6;
                4'h7:    r = `RATIO_7;
                4'h8:    r = `RATIO_8;
                4'h9:    r = `RATIO_9;
                4'hA:    r = `RATIO_10;
                4'hB:    r = `RATIO_11;
                4'hC:    r = `RATIO_12;
                default: r = `RATIO_13;
            endcase
            r = r >> RATIO_SHIFT;
            rate_ratio = (r < 32'd1) ? `CNT_W'h1 : r[`CNT_W-1:0];
        end
    endfunction

    function [`CNT_W-1:0] delay_periods;
        input [2:0] sel;
        reg [31:0] d;
        begin
            case (sel)
                3'h0:    d = `DELAY_DEFAULT;
                3'h1:    d = `DELAY_1;
                3'h2:    d = `DELAY_2;
                3'h3:    d = `DELAY_3;
                3'h4:    d = `DELAY_4;
                3'h5:    d = `DELAY_5;
                3'h6:    d = `DELAY_6;
                default: d = `DELAY_7;
            endcase
            delay_periods = d[`CNT_W-1:0];
        end
    endfunction

    function [5:0] ceil_log2;
        input [`CNT_W-1:0] v;
        integer n;
        begin
            n = 0;
            while (n < 31 && (32'd1 << n) < {12'h0, v}) n = n + 1;
            ceil_log2 = n[5:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    reg start_meta;
    reg start_sync;
    reg start_prev;
    reg mod_meta;
    reg mod_sync;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            start_meta <= 1'b0;
            start_sync <= 1'b0;
            start_prev <= 1'b0;
            mod_meta   <= 1'b0;
            mod_sync   <= 1'b0;
        end else begin
            start_meta <= start_pin;
            start_sync <= start_meta;
            start_prev <= start_sync;
            mod_meta   <= mod_bit;
            mod_sync   <= mod_meta;
        end
    end

    wire go = ((start_sync & ~start_prev) | start_cmd)           // RULE10
              & (filter_sel == `FILTER_SINC);                     // RULE15

    // ------------------------------------------------------------------
    // Modulator tick and sequencer
    // ------------------------------------------------------------------
    reg  [5:0]          state;
    reg  [`MOD_CNT_W-1:0] prescale;
    reg  [`CNT_W-1:0]   seq_cnt;
    reg  [`CNT_W-1:0]   conv_cnt;
    reg  [`CNT_W-1:0]   cfg_ratio;
    reg  [6:0]          cfg_ovh;
    reg  [5:0]          cfg_shift;
    reg                 cfg_cont;
    reg  [1:0]          settle_cnt;
    reg  [15:0]         result;

    wire tick     = (prescale == `MOD_CLKS - 1);              // RULE1 RULE6
    wire sampling = (state == S_SAMPLE) | (state == S_OVH) |
                    (state == S_RELEASE) | (state == S_RUN);
    wire boundary = sampling & tick & (conv_cnt == cfg_ratio - 1'b1); // RULE2
    wire fifo_ready;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            prescale <= {`MOD_CNT_W{1'b0}};
        end else if (go || tick) begin
            prescale <= {`MOD_CNT_W{1'b0}};
        end else begin
            prescale <= prescale + 1'b1;
        end
    end

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state      <= S_IDLE;
            seq_cnt    <= {`CNT_W{1'b0}};
            conv_cnt   <= {`CNT_W{1'b0}};
            cfg_ratio  <= `CNT_W'h1;
            cfg_ovh    <= 7'h0;
            cfg_shift  <= 6'h0;
            cfg_cont   <= 1'b0;
            settle_cnt <= 2'h0;
            data_ready <= 1'b0;
            busy       <= 1'b0;
        end else begin
            data_ready <= 1'b0;
            if (go) begin
                // A new start restarts the whole sequence, settling included
                state      <= S_DELAY;
                seq_cnt    <= delay_periods(delay_sel) - 1'b1;       // RULE11 RULE13
                conv_cnt   <= {`CNT_W{1'b0}};
                settle_cnt <= 2'h0;
                cfg_ratio  <= rate_ratio(rate_sel);                  // RULE3 RULE4 RULE5
                cfg_ovh    <= (rate_sel >= `RATE_FAST_FIRST) ?
                              7'd`OVH_FAST : 7'd`OVH_SLOW;           // RULE8
                cfg_shift  <= 6'd3 * ceil_log2(rate_ratio(rate_sel)) - 6'd16;
                cfg_cont   <= continuous;
                busy       <= 1'b1;
            end else begin
                if (sampling && tick)
                    conv_cnt <= boundary ? {`CNT_W{1'b0}} : conv_cnt + 1'b1;
                case (state)
                    S_DELAY: begin
                        if (tick) begin
                            if (seq_cnt == {`CNT_W{1'b0}})
                                state <= S_SAMPLE;
                            else
                                seq_cnt <= seq_cnt - 1'b1;
                        end
                    end
                    S_SAMPLE: begin
                        if (boundary) begin
                            // Unsettled outputs skip overhead and never leave
                            if (settle_cnt == `SUPPRESSED) begin     // RULE7 RULE14
                                state   <= S_OVH;
                                seq_cnt <= {13'h0, cfg_ovh} - 1'b1;
                            end else begin
                                settle_cnt <= settle_cnt + 1'b1;
                            end
                        end
                    end
                    S_OVH: begin                                     // RULE13
                        if (tick) begin
                            if (seq_cnt == {`CNT_W{1'b0}})
                                state <= S_RELEASE;
                            else
                                seq_cnt <= seq_cnt - 1'b1;
                        end
                    end
                    S_RELEASE: begin
                        // Full FIFO stalls the release; a stall longer than one data period
                        // less the overhead misses the next boundary and loses that result
                        if (fifo_ready) begin
                            data_ready <= 1'b1;                      // RULE17
                            if (cfg_cont) begin
                                state <= S_RUN;                      // RULE12
                            end else begin
                                state <= S_IDLE;                     // RULE16
                                busy  <= 1'b0;
                            end
                        end
                    end
                    S_RUN: begin
                        if (boundary) begin                          // RULE9
                            state   <= S_OVH;
                            seq_cnt <= {13'h0, cfg_ovh} - 1'b1;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                        busy  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Sinc3 integrators and combs
    // ------------------------------------------------------------------
    reg  [`ACC_W-1:0] integ1;
    reg  [`ACC_W-1:0] integ2;
    reg  [`ACC_W-1:0] integ3;
    reg  [`ACC_W-1:0] dly1;
    reg  [`ACC_W-1:0] dly2;
    reg  [`ACC_W-1:0] dly3;
    reg  [`ACC_W-1:0] sample;
    // Comb takes the integrator after this tick, so the first kept output is exact
    wire [`ACC_W-1:0] next_integ3 = integ3 + integ2;
    wire [`ACC_W-1:0] next_comb1 = next_integ3 - dly1;
    wire [`ACC_W-1:0] next_comb2 = next_comb1 - dly2;
    wire [`ACC_W-1:0] next_comb3 = next_comb2 - dly3;
    wire [`ACC_W-1:0] scaled     = sample >> cfg_shift;
    wire [15:0]       clipped    = (|scaled[`ACC_W-1:16]) ? 16'hFFFF : scaled[15:0];

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            integ1 <= {`ACC_W{1'b0}};
            integ2 <= {`ACC_W{1'b0}};
            integ3 <= {`ACC_W{1'b0}};
            dly1   <= {`ACC_W{1'b0}};
            dly2   <= {`ACC_W{1'b0}};
            dly3   <= {`ACC_W{1'b0}};
            sample <= {`ACC_W{1'b0}};
        end else if (go) begin
            integ1 <= {`ACC_W{1'b0}};
            integ2 <= {`ACC_W{1'b0}};
            integ3 <= {`ACC_W{1'b0}};
            dly1   <= {`ACC_W{1'b0}};
            dly2   <= {`ACC_W{1'b0}};
            dly3   <= {`ACC_W{1'b0}};
        end else begin
            if (sampling && tick) begin                              // RULE1
                integ1 <= integ1 + {{(`ACC_W-1){1'b0}}, mod_sync};
                integ2 <= integ2 + integ1;
                integ3 <= integ3 + integ2;
            end
            if (boundary) begin
                dly1   <= next_integ3;
                dly2   <= next_comb1;
                dly3   <= next_comb2;
                sample <= next_comb3;
            end
        end
    end

    // ------------------------------------------------------------------
    // Compensation overhead and release
    // ------------------------------------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            result <= 16'h0000;
        end else if (state == S_OVH) begin
            // Unipolar count to two's complement, then offset removal
            result <= (clipped ^ 16'h8000) - offset_cal;             // RULE13
        end
    end

    result_fifo #(
        .WIDTH (`RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .rst_b     (rst_b),
        .in_valid  (state == S_RELEASE),                             // RULE14
        .in_ready  (fifo_ready),
        .in_data   (result),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

endmodule

`default_nettype wire

/* sinc3_decimator_properties.sv */
// Port-level timing checks for the sinc3 decimator
`include "sinc3_consts.vh"
`default_nettype none

module sinc3_checker #(
    parameter int RATIO_SHIFT = 0
) (
    input wire logic        clock,      // System clock
    input wire logic        rst_b,      // Reset, active low
    input wire logic        start_cmd,  // Start command pulse
    input wire logic        filter_sel, // Filter select
    input wire logic        out_valid,  // Result waiting
    input wire logic        out_ready,  // Host pop
    input wire logic [15:0] out_data,   // Head result
    input wire logic        data_ready, // Release pulse
    input wire logic        busy        // Converting
);
    timeunit 1ns;
    timeprecision 1ns;
    // -------------------------------------------------------------
    // Helper counters
    // -------------------------------------------------------------
    // Fastest code with default delay bounds every first result
    localparam int R_MIN     = `RATIO_13 >> RATIO_SHIFT;
    localparam int MIN_FIRST = `MOD_CLKS * (`DELAY_DEFAULT + 3 * R_MIN + `OVH_FAST);
    localparam int MIN_GAP   = `MOD_CLKS * R_MIN - 1;
    logic [19:0] since;
    logic [19:0] since_dr;
    logic        first_pend;
    logic [3:0]  idle;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            since      <= 20'h00000;
            since_dr   <= 20'h00000;
            first_pend <= 1'b0;
            idle       <= 4'h0;
        end else begin
            since      <= (start_cmd && !filter_sel) ? 20'h00000 : since + {19'h0, ~&since};
            since_dr   <= data_ready ? 20'h00000 : since_dr + {19'h0, ~&since_dr};
            first_pend <= (start_cmd && !filter_sel) | (first_pend & ~data_ready);
            idle       <= busy ? 4'h0 : idle + {3'h0, ~&idle};
        end
    end

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    pulse_once_a: assert property (data_ready |=> !data_ready)
        else $error("data ready held longer than one cycle");
    ready_has_word_a: assert property (data_ready |-> out_valid)
        else $error("data ready without a stored result");
    first_late_a: assert property (data_ready && first_pend |-> since >= MIN_FIRST)
        else $error("first result came before settling");
    data_gap_a: assert property (data_ready && !first_pend |-> since_dr >= MIN_GAP)
        else $error("results closer than one data period");
    start_busy_a: assert property (start_cmd && !filter_sel |=> busy)
        else $error("start command not taken");
    sel_block_a: assert property (start_cmd && filter_sel && !busy |=> !busy)
        else $error("start taken with filter deselected");
    word_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("unread result changed or vanished");
    idle_quiet_a: assert property (idle == 4'hF |-> !data_ready)
        else $error("result released while stopped");
endmodule

bind sinc3_decimator sinc3_checker #(.RATIO_SHIFT(RATIO_SHIFT)) chk (
    .clock(clock), .rst_b(rst_b), .start_cmd(start_cmd), .filter_sel(filter_sel),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .data_ready(data_ready), .busy(busy));

`default_nettype wire

/* stream_partner.sv */
// Modulator bit source and stalling host reader around the decimator
`default_nettype none

module stream_partner (
    input  wire logic clock,     // System clock
    input  wire logic mod_level, // Level to stream
    input  wire logic host_go,   // Host may read
    output var  logic mod_bit,   // Modulator bit line
    output var  logic out_ready  // Host pop request
);
    timeunit 1ns;
    timeprecision 1ns;
    int seed = 52;

    initial begin
        mod_bit   = 1'b0;
        out_ready = 1'b0;
    end

    // Random stalls keep back-pressure on the result FIFO
    always @(negedge clock) begin
        mod_bit   <= mod_level;
        out_ready <= host_go & 1'($random(seed));
    end
endmodule

`default_nettype wire

/* tb.sv */
// Self-checking bench: conversion timing, suppression, FIFO and values
`include "sinc3_consts.vh"
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock      = 1'b0;
    logic        rst_b      = 1'b0;
    logic        start_pin  = 1'b0;
    logic        start_cmd  = 1'b0;
    logic        filter_sel = 1'b0;
    logic        continuous = 1'b0;
    logic [3:0]  rate_sel   = 4'hD;
    logic [2:0]  delay_sel  = 3'h0;
    logic [15:0] offset_cal = 16'h0000;
    logic        mod_level  = 1'b0;
    logic        host_go    = 1'b1;
    logic [15:0] exp_word   = 16'h0000;
    wire         mod_bit, out_valid, out_ready, data_ready, busy;
    wire  [15:0] out_data;
    int          seed = 52;
    int          error_cnt = 0, num_checks = 0, cyc = 0, go = 0, pops = 0, base;
    int          dr_t[$];

    always #50 clock = ~clock;

    sinc3_decimator #(.RATIO_SHIFT(0), .FIFO_DEPTH(8)) dut (
        .clock(clock), .rst_b(rst_b), .start_pin(start_pin), .start_cmd(start_cmd),
        .mod_bit(mod_bit), .filter_sel(filter_sel), .continuous(continuous),
        .rate_sel(rate_sel), .delay_sel(delay_sel), .offset_cal(offset_cal),
        .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
        .data_ready(data_ready), .busy(busy));

    stream_partner partner (.clock(clock), .mod_level(mod_level), .host_go(host_go),
        .mod_bit(mod_bit), .out_ready(out_ready));

    // -------------------------------------------------------------
    // Reference model
    // -------------------------------------------------------------
    function int ratio(input int c);
        case (c)
            10: return `RATIO_10;
            11: return `RATIO_11;
            12: return `RATIO_12;
            default: return `RATIO_13;
        endcase
    endfunction

    function int first_n(input int c, input int d);
        int o;
        o = (c >= `RATE_FAST_FIRST) ? `OVH_FAST : `OVH_SLOW;
        // One clock for the push, one for the registered pulse seen at the next edge
        return `MOD_CLKS * ((d == 0 ? `DELAY_DEFAULT : `DELAY_1) + 3 * ratio(c) + o) + 2;
    endfunction

    // Constant input settles to ratio cubed, then scaled and offset
    function logic [15:0] value(input int c, input logic b, input logic [15:0] off);
        longint s;
        s = b ? longint'(ratio(c)) ** 3 : 0;
        s = s >> (3 * $clog2(ratio(c)) - 16);
        if (s > 65535)
            s = 65535;
        return (16'(s) ^ 16'h8000) - off;
    endfunction

    // -------------------------------------------------------------
    // Monitor and tasks
    // -------------------------------------------------------------
    always @(posedge clock) begin
        if (start_cmd === 1'b1 && filter_sel === 1'b0)
            go = cyc;
        if (data_ready === 1'b1)
            dr_t.push_back(cyc);
        if (out_valid === 1'b1 && out_ready === 1'b1) begin
            check(out_data, exp_word);
            pops++;
        end
        cyc++;
    end

    task check(input logic [31:0] seen, input logic [31:0] want);
        num_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task stop_test();
        $display("Checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task start(input int c, input int d, input int cont, input int pin);
        @(negedge clock);
        rate_sel   = c[3:0];
        delay_sel  = d[2:0];
        continuous = cont[0];
        offset_cal = 16'($random(seed));
        mod_level  = 1'($random(seed));
        exp_word   = value(c, mod_level, offset_cal);
        dr_t.delete();
        if (pin) begin
            start_pin = 1'b1;
            go = cyc + 2;
        end else
            start_cmd = 1'b1;
        @(negedge clock);
        start_pin = 1'b0;
        start_cmd = 1'b0;
    endtask

    task run(input int c, input int d, input int cont, input int pin, input int n);
        int i;
        start(c, d, cont, pin);
        for (i = 0; i < first_n(c, d) + n * 16 * ratio(c) + 100 && dr_t.size() < n; i++)
            @(negedge clock);
        if (dr_t.size() < n) begin
            check(dr_t.size(), n);
            stop_test();
        end
        check(dr_t[0] - go, first_n(c, d));
        for (i = 1; i < n; i++)
            check(dr_t[i] - dr_t[i-1], 16 * ratio(c));
        repeat (50) @(negedge clock);
    endtask

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        rst_b = 1'b1;
        for (int c = 10; c <= 13; c++) begin
            base = pops;
            run(c, 0, 0, 0, 1);
            repeat (2000) @(negedge clock);
            check(dr_t.size(), 1);
            check(pops - base, 1);
            check(busy, 1'b0);
            $display("Test single-shot rate %0d done", c);
        end
        run(13, 1, 1, 1, 4);
        $display("Test continuous pin start done");
        start(13, 0, 0, 0);
        repeat (1000) @(negedge clock);
        run(13, 0, 0, 0, 1);
        $display("Test restart done");
        filter_sel = 1'b1;
        start(13, 0, 0, 0);
        repeat (200) @(negedge clock);
        check(busy, 1'b0);
        check(dr_t.size(), 0);
        filter_sel = 1'b0;
        $display("Test filter deselect done");
        // Host stalls until the FIFO refuses the ninth result
        host_go = 1'b0;
        run(13, 0, 1, 0, 8);
        repeat (1200) @(negedge clock);
        check(dr_t.size(), 8);
        check(out_valid, 1'b1);
        base = pops;
        host_go = 1'b1;
        for (int i = 0; i < 400 && pops - base < 8; i++)
            @(negedge clock);
        check(pops - base >= 8, 1'b1);
        rst_b = 1'b0;
        repeat (2) @(negedge clock);
        check(out_valid, 1'b0);
        check(busy, 1'b0);
        rst_b = 1'b1;
        $display("Test FIFO fill and reset done");
        stop_test();
    end
endmodule

`default_nettype wire
